// file: src/mis_core.sv
// Instruction format decoder and executor for a subset of an 8-bit core
// Overview of operation
// - Byte ops: destination bit 0 writes working register, 1 writes file.
// - Access bit 0 uses fixed access bank, 1 uses bank select register.
// - Byte and bit ops carry 8-bit file address in low bits.
// - Register move: two words, 12-bit source then destination, tag 1111.
// - Bit ops decode a 3-bit bit position plus access and address.
// - Literal ops take 8-bit immediate from low byte.
// - Jump and call: 20-bit target, low byte first, upper 12 tagged.
// - Call's first word holds a fast bit selecting fast context save.
// - Relative branch: 11-bit signed offset under a 5-bit opcode.
// - Conditional branch: 8-bit signed offset in low byte.
// - Increment adds one; sets carry, digit carry, N, overflow, Z.
// - OR-register ORs working and file register; N and Z only.
// - Single-word ops: decode, read, compute, write over four phases.
`timescale 1ns/100ps
`include "mis_core_map.svh"
module mis_core
   import mis_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input  wire logic              clk_sys_in,
   input  wire logic              nrst_in,
   input  wire logic              psel_in,
   input  wire logic              penable_in,
   input  wire logic              pwrite_in,
   input  wire logic [11:0]       paddr_in,
   input  wire logic [31:0]       pwdata_in,
   output logic      [31:0]       prdata_out,
   output logic                   pready_out,
   output logic                   pslverr_out
);
   localparam int DEPTH = 1 << ADDR_W;

   mis_state_t        state_q;
   mis_class_t        cls_q;
   mis_class_t        dec_cls;
   logic [15:0]       iw_q;
   logic              sec_q;
   logic              dst_q;
   logic [ADDR_W-1:0] fadr_q;
   logic [2:0]        bit_q;
   logic [7:0]        lit_q;
   logic [19:0]       tgt_q;
   logic [10:0]       off_q;
   logic              fast_q;
   logic              badsec_q;
   logic [1:0]        nop_q;
   logic [7:0]        opnd_q;
   logic [7:0]        res_q;
   logic [4:0]        flg_q;
   logic [7:0]        working_register_q;
   logic [3:0]        bank_q;
   logic [20:0]       pc_q;
   logic [20:0]       ret_q;
   logic [7:0]        sh_w_q;
   logic [4:0]        sh_flg_q;
   logic [3:0]        sh_bank_q;
   logic [ADDR_W-1:0] faddr_q;
   logic [7:0]        mem [DEPTH];
   logic              acc_now;
   logic              wr_now;
   logic              busy;
   logic              hit;
   logic              refuse;
   logic [31:0]       rd_val;
   logic [8:0]        sum;
   logic [7:0]        ior;
   logic [20:0]       br_tgt;
   logic              ex_wr_f;
   logic              ex_wr_w;

   // Decode class of a first instruction word
   always_comb begin
      dec_cls = MIS_NONE;
      if (iw_q[15:10] == 6'b0010_10) begin
         dec_cls = MIS_INC;
      end else if (iw_q[15:10] == 6'b0001_00) begin
         dec_cls = MIS_ORREG;
      end else if (iw_q[15:8] == 8'h09) begin
         dec_cls = MIS_ORLIT;
      end else if (iw_q[15:8] == 8'h0e) begin
         dec_cls = MIS_LDLIT;
      end else if (iw_q[15:12] == 4'h8) begin
         dec_cls = MIS_BSET;
      end else if (iw_q[15:12] == 4'h9) begin
         dec_cls = MIS_BCLR;
      end else if (iw_q[15:12] == 4'hc) begin
         dec_cls = MIS_MOVE;
      end else if (iw_q[15:8] == 8'hef) begin
         dec_cls = MIS_JUMP;
      end else if (iw_q[15:9] == 7'b1110_110) begin
         dec_cls = MIS_CALL;
      end else if (iw_q[15:11] == 5'b11010) begin
         dec_cls = MIS_BRA;
      end else if (iw_q[15:8] == 8'he2) begin
         dec_cls = MIS_BCARRY;
      end
   end
   // APB access phase and decode; offsets are contiguous aligned words
   assign acc_now = psel_in & penable_in & pready_out;
   assign busy    = (state_q != MIS_IDLE) && (state_q != MIS_WAIT2);
   assign hit     = (paddr_in <= `MIS_OFF_RETURN) && (paddr_in[1:0] == 2'h0);
   // Writes while executing would race the datapath, so they are refused
   assign refuse = !hit || (pwrite_in && busy);
   assign wr_now = acc_now & pwrite_in & !refuse;
   // Read mux
   always_comb begin
      rd_val = 32'h0000_0000;
      if (paddr_in == `MIS_OFF_INSTR) begin
         rd_val = {16'h0000, iw_q};
      end else if (paddr_in == `MIS_OFF_STATUS) begin
         rd_val = {16'h0000, cls_q, badsec_q, fast_q, state_q == MIS_WAIT2,
                   busy, 3'h0, flg_q};
      end else if (paddr_in == `MIS_OFF_WORK) begin
         rd_val = {24'h00_0000, working_register_q};
      end else if (paddr_in == `MIS_OFF_BANK) begin
         rd_val = {28'h000_0000, bank_q};
      end else if (paddr_in == `MIS_OFF_PC) begin
         rd_val = {11'h000, pc_q};
      end else if (paddr_in == `MIS_OFF_FADDR) begin
         rd_val = 32'(faddr_q);
      end else if (paddr_in == `MIS_OFF_FDATA) begin
         rd_val = {24'h00_0000, mem[faddr_q]};
      end else if (paddr_in == `MIS_OFF_FIELDS) begin
         rd_val = {5'h00, off_q, lit_q, 5'h00, bit_q};
      end else if (paddr_in == `MIS_OFF_TARGET) begin
         rd_val = {12'h000, tgt_q};
      end else if (paddr_in == `MIS_OFF_RETURN) begin
         rd_val = {11'h000, ret_q};
      end
   end

   // One wait state: ready rises in the second access cycle
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pready_out  <= 1'b0;
         prdata_out  <= 32'h0000_0000;
         pslverr_out <= 1'b0;
      end else begin
         pready_out  <= psel_in & penable_in & !pready_out;
         pslverr_out <= psel_in & penable_in & !pready_out & refuse;
         if (psel_in & penable_in & !pready_out & !pwrite_in) begin
            prdata_out <= hit ? rd_val : 32'h0000_0000;
         end
      end
   end

   // Instruction word latch from software
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         iw_q <= 16'h0000;
      end else if (wr_now && paddr_in == `MIS_OFF_INSTR) begin
         iw_q <= pwdata_in[15:0];
      end
   end

   // Phase sequencer
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_q <= MIS_IDLE;
         sec_q   <= 1'b0;
         nop_q   <= 2'h0;
      end else begin
         case (state_q)
            MIS_IDLE, MIS_WAIT2: begin
               if (wr_now && paddr_in == `MIS_OFF_INSTR) begin
                  state_q <= MIS_Q1;
               end
            end
            MIS_Q1: begin
               state_q <= MIS_Q2;
            end
            MIS_Q2: begin
               state_q <= MIS_Q3;
            end
            MIS_Q3: begin
               state_q <= MIS_Q4;
            end
            MIS_Q4: begin
               nop_q <= 2'h0;
               if (!sec_q && (cls_q == MIS_MOVE || cls_q == MIS_JUMP
                              || cls_q == MIS_CALL)) begin
                  state_q <= MIS_WAIT2;
                  sec_q   <= 1'b1;
               end else begin
                  sec_q <= 1'b0;
                  // Program flow changes cost four dead cycles
                  if (cls_q == MIS_JUMP || cls_q == MIS_CALL
                      || cls_q == MIS_BRA
                      || (cls_q == MIS_BCARRY && flg_q[`MIS_FLG_C])) begin
                     state_q <= MIS_NOP;
                  end else begin
                     state_q <= MIS_IDLE;
                  end
               end
            end
            MIS_NOP: begin
               nop_q <= nop_q + 2'h1;
               if (nop_q == `MIS_NOP_PHASES) begin
                  state_q <= MIS_IDLE;
               end
            end
            default: begin
               state_q <= MIS_IDLE;
            end
         endcase
      end
   end

   // Field extraction in the decode phase
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cls_q    <= MIS_NONE;
         dst_q    <= 1'b0;
         fadr_q   <= '0;
         bit_q    <= 3'h0;
         lit_q    <= 8'h00;
         tgt_q    <= 20'h0_0000;
         off_q    <= 11'h000;
         fast_q   <= 1'b0;
         badsec_q <= 1'b0;
      end else if (state_q == MIS_Q1 && !sec_q) begin
         cls_q    <= dec_cls;
         badsec_q <= 1'b0;
         dst_q    <= iw_q[9];
         bit_q    <= iw_q[11:9];
         lit_q    <= iw_q[7:0];
         tgt_q    <= {12'h000, iw_q[7:0]};
         off_q    <= (dec_cls == MIS_BRA) ? iw_q[10:0]
                   : {{3{iw_q[7]}}, iw_q[7:0]};
         if (dec_cls == MIS_CALL) begin
            fast_q <= iw_q[8];
         end
         if (dec_cls == MIS_MOVE) begin
            fadr_q <= ADDR_W'(iw_q[11:0]);
         end else if (!iw_q[8]) begin
            // Access bank: low half at bank 0, high half at top bank
            fadr_q <= ADDR_W'({iw_q[7] ? `MIS_ACC_HI_BANK : 4'h0,
                               iw_q[7:0]});
         end else begin
            fadr_q <= ADDR_W'({bank_q, iw_q[7:0]});
         end
      end else if (state_q == MIS_Q1) begin
         if (iw_q[15:12] != `MIS_SECOND_TAG) begin
            // Untagged second word executes as a no-op
            badsec_q <= 1'b1;
            cls_q    <= MIS_NONE;
         end else begin
            tgt_q[19:8] <= iw_q[11:0];
            fadr_q      <= ADDR_W'(iw_q[11:0]);
         end
      end
   end

   // Operand read, compute and flags
   assign sum = {1'b0, opnd_q} + 9'h001;
   assign ior = working_register_q | opnd_q;
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         opnd_q <= 8'h00;
         res_q  <= 8'h00;
         flg_q  <= 5'h00;
      end else if (state_q == MIS_Q2) begin
         if (cls_q == MIS_ORLIT || cls_q == MIS_LDLIT) begin
            opnd_q <= lit_q;
         end else if (!sec_q && cls_q != MIS_NONE) begin
            opnd_q <= mem[fadr_q];
         end
      end else if (state_q == MIS_Q3) begin
         case (cls_q)
            MIS_INC: begin
               res_q              <= sum[7:0];
               flg_q[`MIS_FLG_C]  <= sum[8];
               flg_q[`MIS_FLG_DCY] <= opnd_q[3:0] == 4'hf;
               flg_q[`MIS_FLG_Z]  <= sum[7:0] == 8'h00;
               flg_q[`MIS_FLG_OVF] <= opnd_q == 8'h7f;
               flg_q[`MIS_FLG_N]  <= sum[7];
            end
            MIS_ORREG, MIS_ORLIT: begin
               res_q              <= ior;
               flg_q[`MIS_FLG_Z]  <= ior == 8'h00;
               flg_q[`MIS_FLG_N]  <= ior[7];
            end
            MIS_BSET: begin
               res_q <= opnd_q | (8'h01 << bit_q);
            end
            MIS_BCLR: begin
               res_q <= opnd_q & ~(8'h01 << bit_q);
            end
            default: begin
               res_q <= opnd_q;
            end
         endcase
      end
   end

   // Destination selection for the write phase
   assign ex_wr_f = state_q == MIS_Q4 && (
      ((cls_q == MIS_INC || cls_q == MIS_ORREG) && dst_q)
      || cls_q == MIS_BSET || cls_q == MIS_BCLR
      || (cls_q == MIS_MOVE && sec_q));
   assign ex_wr_w = state_q == MIS_Q4 && (
      ((cls_q == MIS_INC || cls_q == MIS_ORREG) && !dst_q)
      || cls_q == MIS_ORLIT || cls_q == MIS_LDLIT);
   // File register array, shared by software and the write phase
   always_ff @(posedge clk_sys_in) begin
      if (ex_wr_f) begin
         mem[fadr_q] <= res_q;
      end else if (wr_now && paddr_in == `MIS_OFF_FDATA) begin
         mem[faddr_q] <= pwdata_in[7:0];
      end
   end

   // Working register, bank select and software file pointer
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         working_register_q  <= 8'h00;
         bank_q  <= 4'h0;
         faddr_q <= '0;
      end else begin
         if (ex_wr_w) begin
            working_register_q <= res_q;
         end else if (wr_now && paddr_in == `MIS_OFF_WORK) begin
            working_register_q <= pwdata_in[7:0];
         end
         if (wr_now && paddr_in == `MIS_OFF_BANK) begin
            bank_q <= pwdata_in[3:0];
         end
         if (wr_now && paddr_in == `MIS_OFF_FADDR) begin
            faddr_q <= pwdata_in[ADDR_W-1:0];
         end
      end
   end
   // Branch target: next word plus twice the signed offset
   assign br_tgt = pc_q + 21'h2 + {{9{off_q[10]}}, off_q, 1'b0};
   // Program counter, return address and fast context shadows
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pc_q      <= `MIS_RST_PC;
         ret_q     <= `MIS_RST_PC;
         sh_w_q    <= 8'h00;
         sh_flg_q  <= 5'h00;
         sh_bank_q <= 4'h0;
      end else if (state_q == MIS_Q4) begin
         if ((cls_q == MIS_JUMP || cls_q == MIS_CALL) && sec_q) begin
            pc_q <= {tgt_q, 1'b0};
            if (cls_q == MIS_CALL) begin
               ret_q <= pc_q + 21'h2;
               if (fast_q) begin
                  sh_w_q    <= working_register_q;
                  sh_flg_q  <= flg_q;
                  sh_bank_q <= bank_q;
               end
            end
         end else if (cls_q == MIS_BRA
                      || (cls_q == MIS_BCARRY && flg_q[`MIS_FLG_C])) begin
            pc_q <= br_tgt;
         end else begin
            pc_q <= pc_q + 21'h2;
         end
      end
   end
endmodule

// file: src/mis_core_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef MIS_CORE_MAP_SVH
`define MIS_CORE_MAP_SVH
`define MIS_OFF_INSTR   12'h000
`define MIS_OFF_STATUS  12'h004
`define MIS_OFF_WORK    12'h008
`define MIS_OFF_BANK    12'h00c
`define MIS_OFF_PC      12'h010
`define MIS_OFF_FADDR   12'h014
`define MIS_OFF_FDATA   12'h018
`define MIS_OFF_FIELDS  12'h01c
`define MIS_OFF_TARGET  12'h020
`define MIS_OFF_RETURN  12'h024
`define MIS_FLG_C       0
`define MIS_FLG_DCY     1
`define MIS_FLG_Z       2
`define MIS_FLG_OVF     3
`define MIS_FLG_N       4
`define MIS_ST_BUSY     8
`define MIS_ST_WAIT2    9
`define MIS_ST_FAST     10
`define MIS_ST_BADSEC   11
`define MIS_ST_CLS_LO   12
`define MIS_RST_PC      21'h000000
`define MIS_ACC_HI_BANK 4'hf
`define MIS_SECOND_TAG  4'hf
`define MIS_NOP_PHASES  2'h3
`endif

// file: src/mis_pkg.sv
// Types shared by the instruction decoder
package mis_pkg;
   typedef enum logic [2:0] {
      MIS_IDLE, MIS_Q1, MIS_Q2, MIS_Q3, MIS_Q4, MIS_WAIT2, MIS_NOP
   } mis_state_t;
   typedef enum logic [3:0] {
      MIS_NONE, MIS_INC, MIS_ORREG, MIS_ORLIT, MIS_LDLIT, MIS_BSET,
      MIS_BCLR, MIS_MOVE, MIS_JUMP, MIS_CALL, MIS_BRA, MIS_BCARRY
   } mis_class_t;
endpackage

// file: testbench/mis_core_chk.sv
// Bus timing and read-data checks on the decoder's APB ports
`timescale 1ns/100ps
`include "mis_core_map.svh"
module mis_core_chk #(
   parameter int ADDR_W = 12
) (
   input wire logic        clk_sys_in,
   input wire logic        nrst_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic        pslverr_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   // Decode helpers; misaligned offsets count as unmapped
   wire logic rd_done = pready_out && psel_in && !pwrite_in;
   wire logic mapped = (paddr_in <= 12'h024) && (paddr_in[1:0] == 2'h0);
   property p_wait_one;
      (psel_in && !penable_in) ##1 (psel_in && penable_in)
         |-> !pready_out ##1 pready_out;
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("ready not on second access cycle");
   property p_ready_pulse;
      pready_out |=> !pready_out;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready longer than one cycle");
   property p_ready_access;
      pready_out |-> psel_in && penable_in;
   endproperty
   a_ready_access: assert property (p_ready_access)
      else $error("ready outside access phase");
   property p_err_ready;
      pslverr_out |-> pready_out;
   endproperty
   a_err_ready: assert property (p_err_ready)
      else $error("error without ready");
   property p_unmapped;
      pready_out && !mapped |-> pslverr_out && (pwrite_in || prdata_out == 0);
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access not refused");
   property p_read_ok;
      rd_done && mapped |-> !pslverr_out;
   endproperty
   a_read_ok: assert property (p_read_ok)
      else $error("mapped read refused");
   property p_rdata_hold;
      !rd_done |-> $stable(prdata_out);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data moved without a read");
   property p_w_width;
      rd_done && paddr_in == `MIS_OFF_WORK |-> prdata_out[31:8] == 24'h0;
   endproperty
   a_w_width: assert property (p_w_width)
      else $error("working register wider than a byte");
   property p_pc_even;
      rd_done && paddr_in == `MIS_OFF_PC
         |-> !prdata_out[0] && prdata_out[31:21] == 11'h0;
   endproperty
   a_pc_even: assert property (p_pc_even)
      else $error("program counter odd or too wide");
   property p_fields;
      rd_done && paddr_in == `MIS_OFF_FIELDS
         |-> prdata_out[7:3] == 5'h0 && prdata_out[31:27] == 5'h0;
   endproperty
   a_fields: assert property (p_fields)
      else $error("field register spare bits set");
   // Main traffic kinds
   c_write: cover property (pready_out && pwrite_in);
   c_read: cover property (rd_done && mapped);
   c_refused: cover property (pslverr_out);
endmodule
bind mis_core mis_core_chk #(.ADDR_W(ADDR_W)) mis_core_chk_inst (
   .clk_sys_in  (clk_sys_in),
   .nrst_in     (nrst_in),
   .psel_in     (psel_in),
   .penable_in  (penable_in),
   .pwrite_in   (pwrite_in),
   .paddr_in    (paddr_in),
   .pwdata_in   (pwdata_in),
   .prdata_out  (prdata_out),
   .pready_out  (pready_out),
   .pslverr_out (pslverr_out)
);

// file: testbench/mis_apb_host.sv
// APB master standing in for the software side of the decoder
`timescale 1ns/100ps
module mis_apb_host (
   input  wire logic        clk_sys_in,
   input  wire logic [31:0] prdata_in,
   input  wire logic        pready_in,
   input  wire logic        pslverr_in,
   output logic             psel_out,
   output logic             penable_out,
   output logic             pwrite_out,
   output logic      [11:0] paddr_out,
   output logic      [31:0] pwdata_out
);
   // Idle bus from time zero
   initial begin
      psel_out = 1'b0;
      penable_out = 1'b0;
      pwrite_out = 1'b0;
      paddr_out = 12'h0;
      pwdata_out = 32'h0;
   end
   // One transfer; request held until ready is seen at a rising edge
   task automatic xfer(input logic wr, input logic [11:0] addr,
                       input logic [31:0] wdat, output logic [31:0] rdat,
                       output logic err);
      @(posedge clk_sys_in);
      psel_out <= 1'b1;
      penable_out <= 1'b0;
      pwrite_out <= wr;
      paddr_out <= addr;
      pwdata_out <= wdat;
      @(posedge clk_sys_in);
      penable_out <= 1'b1;
      @(posedge clk_sys_in);
      while (pready_in !== 1'b1) @(posedge clk_sys_in);
      // Values seen here are those sampled by this edge
      rdat = prdata_in;
      err = pslverr_in;
      psel_out <= 1'b0;
      penable_out <= 1'b0;
      paddr_out <= ~addr; // Stale values must not look valid
      pwdata_out <= ~wdat;
   endtask
endmodule

// file: testbench/mis_core_test.sv
// Register-level tests of the instruction decoder
`timescale 1ns/100ps
`include "mis_core_map.svh"
module mis_core_test;
   logic        clk_sys_in;
   logic        nrst_in;
   wire  logic  psel, penable, pwrite, pready, pslverr;
   wire  logic [11:0] paddr;
   wire  logic [31:0] pwdata, prdata;
   int          fail_count;
   int          samples_checked;
   logic [31:0] rdat;
   logic        err;
   mis_core mis_core_inst (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr));
   mis_apb_host mis_apb_host_inst (.clk_sys_in(clk_sys_in),
      .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr),
      .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
      .paddr_out(paddr), .pwdata_out(pwdata));
   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk_data(input string n, input logic [31:0] e,
                           input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_err(input string n, input logic e);
      samples_checked++;
      if (err !== e) begin
         fail_count++;
         $display("BAD %s expected %b seen %b", n, e, err);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      mis_apb_host_inst.xfer(1'b1, a, d, rdat, err);
   endtask
   task automatic rd(input logic [11:0] a);
      mis_apb_host_inst.xfer(1'b0, a, 32'h0, rdat, err);
   endtask
   task automatic rd_chk(input string n, input logic [11:0] a,
                         input logic [31:0] m, input logic [31:0] e);
      rd(a);
      chk_data(n, e, rdat & m);
   endtask
   // Bounded poll; a stuck busy shows up as a mismatch
   task automatic wait_idle;
      for (int i = 0; i < 50; i++) begin
         rd(`MIS_OFF_STATUS);
         if (rdat[8] === 1'b0) break;
      end
      chk_data("busy", 32'h0, {31'h0, rdat[8]});
   endtask
   task automatic exec(input logic [15:0] ins);
      wr(`MIS_OFF_INSTR, {16'h0, ins});
      wait_idle();
   endtask
   task automatic poke(input logic [11:0] a, input logic [7:0] v);
      wr(`MIS_OFF_FADDR, {20'h0, a});
      wr(`MIS_OFF_FDATA, {24'h0, v});
   endtask
   // 50 MHz clock
   initial begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end
   // Hang guard, far beyond the several hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      fail_count++;
      stop_test();
   end
   // Main sequence
   initial begin
      nrst_in = 1'b0;
      fail_count = 0;
      samples_checked = 0;
      repeat (16) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      rd_chk("status_rst", `MIS_OFF_STATUS, 32'hffff, 32'h0);
      rd_chk("pc_rst", `MIS_OFF_PC, 32'hffffffff, 32'h0);
      rd(12'h028);
      chk_err("unmapped_err", 1'b1);
      chk_data("unmapped_data", 32'h0, rdat);
      poke(12'h012, 8'hff);
      exec(16'h2a12);
      rd_chk("inc_wrap", `MIS_OFF_FDATA, 32'hff, 32'h0);
      rd_chk("inc_flags", `MIS_OFF_STATUS, 32'hffff, 32'h1007);
      rd_chk("pc_step", `MIS_OFF_PC, 32'hffffffff, 32'h2);
      rd_chk("w_kept", `MIS_OFF_WORK, 32'hff, 32'h0);
      wr(`MIS_OFF_BANK, 32'h2);
      poke(12'h234, 8'h7f);
      exec(16'h2934);
      rd_chk("inc_to_w", `MIS_OFF_WORK, 32'hff, 32'h80);
      rd_chk("inc_ovf", `MIS_OFF_STATUS, 32'hffff, 32'h101a);
      rd_chk("file_kept", `MIS_OFF_FDATA, 32'hff, 32'h7f);
      poke(12'hf85, 8'h0f);
      exec(16'h2a85);
      rd_chk("acc_high", `MIS_OFF_FDATA, 32'hff, 32'h10);
      rd_chk("inc_half", `MIS_OFF_STATUS, 32'hffff, 32'h1002);
      wr(`MIS_OFF_WORK, 32'h9a);
      exec(16'h0935);
      rd_chk("orl_w", `MIS_OFF_WORK, 32'hff, 32'hbf);
      rd_chk("orl_flags", `MIS_OFF_STATUS, 32'hffff, 32'h3012);
      rd_chk("literal", `MIS_OFF_FIELDS, 32'hff00, 32'h3500);
      wr(`MIS_OFF_WORK, 32'h13);
      poke(12'h013, 8'h80);
      exec(16'h1013);
      rd_chk("orw_w", `MIS_OFF_WORK, 32'hff, 32'h93);
      rd_chk("orw_flags", `MIS_OFF_STATUS, 32'hffff, 32'h2012);
      wr(`MIS_OFF_WORK, 32'h0);
      poke(12'h013, 8'h00);
      exec(16'h1213);
      rd_chk("orw_zero", `MIS_OFF_STATUS, 32'hffff, 32'h2006);
      exec(16'h8a12);
      wr(`MIS_OFF_FADDR, 32'h012);
      rd_chk("bit_set", `MIS_OFF_FDATA, 32'hff, 32'h20);
      rd_chk("bit_num", `MIS_OFF_FIELDS, 32'h7, 32'h5);
      exec(16'hc012);
      rd_chk("move_wait", `MIS_OFF_STATUS, 32'h200, 32'h200);
      exec(16'hf020);
      wr(`MIS_OFF_FADDR, 32'h020);
      rd_chk("move_dst", `MIS_OFF_FDATA, 32'hff, 32'h20);
      exec(16'hef56);
      exec(16'hf123);
      rd_chk("jump_pc", `MIS_OFF_PC, 32'hffffffff, 32'h246ac);
      rd_chk("jump_tgt", `MIS_OFF_TARGET, 32'hfffff, 32'h12356);
      exec(16'hed78);
      exec(16'hf000);
      rd_chk("call_tgt", `MIS_OFF_TARGET, 32'hfffff, 32'h78);
      rd_chk("call_fast", `MIS_OFF_STATUS, 32'hf400, 32'h9400);
      rd_chk("call_ret", `MIS_OFF_RETURN, 32'hffffffff, 32'h246b0);
      rd_chk("call_pc", `MIS_OFF_PC, 32'hffffffff, 32'hf0);
      exec(16'hd400);
      rd_chk("bra_off", `MIS_OFF_FIELDS, 32'h7ff0000, 32'h4000000);
      rd_chk("bra_cls", `MIS_OFF_STATUS, 32'hf000, 32'ha000);
      rd_chk("bra_pc", `MIS_OFF_PC, 32'hffffffff, 32'h1ff8f2);
      exec(16'he280);
      rd_chk("bcy_off", `MIS_OFF_FIELDS, 32'h7ff0000, 32'h7800000);
      rd_chk("bcy_cls", `MIS_OFF_STATUS, 32'hf000, 32'hb000);
      rd_chk("bcy_idle", `MIS_OFF_PC, 32'hffffffff, 32'h1ff8f4);
      // Carry set by a wrapping increment, then a taken branch back
      poke(12'h012, 8'hff);
      exec(16'h2a12);
      exec(16'he2fe);
      rd_chk("bcy_taken", `MIS_OFF_PC, 32'hffffffff, 32'h1ff8f4);
      poke(12'h012, 8'hff);
      exec(16'h9e12);
      rd_chk("bit_clr", `MIS_OFF_FDATA, 32'hff, 32'h7f);
      exec(16'hef00);
      exec(16'h0123);
      rd_chk("bad_second", `MIS_OFF_STATUS, 32'h800, 32'h800);
      exec(16'h0e5a);
      rd_chk("lit_load", `MIS_OFF_WORK, 32'hff, 32'h5a);
      exec(16'hef00);
      wr(`MIS_OFF_INSTR, 32'hf000);
      wr(`MIS_OFF_WORK, 32'h55);
      chk_err("busy_refuse", 1'b1);
      wait_idle();
      rd_chk("w_unchanged", `MIS_OFF_WORK, 32'hff, 32'h5a);
      stop_test();
   end
endmodule
